//--- rtl/rcs_defines.svh
`ifndef RCS_DEFINES_SVH
`define RCS_DEFINES_SVH
// Function
// R1: Brown-out cannot reset the device until software enables it.
// R2: Brown-out raises an interrupt, or a reset when the enable bit is set.
// R3: Brown-out reset acts like the external reset, held until supply recovers.
// R4: Reset cause shows a brown-out was the source of the last reset.
// R5: Three peripheral reset registers, one bit each; set then clear resets it.
// R6: Peripheral reset bit positions match clock gating bit positions.
// R7: Software peripheral reset asserts resets of every clock domain of the unit.
// R8: System reset request resets the whole system including the core.
// R9: Software or watchdog request asserts internal reset, then releases it.
// R10: Watchdog interrupts on first time-out and resets on second.
// R11: After first time-out the 32-bit counter reloads from the load value.
// R12: Watchdog resets only if zero reached again, interrupt uncleared, reset enabled.
// R13: Regulator voltage follows the adjust field within 2.25 V to 2.75 V.
// R14: The 12 MHz internal oscillator is selected during and after power-on reset.
// R15: Software enables main oscillator and waits for it before switching to it.
// R16: System clock comes from any oscillator, the PLL, or internal osc over four.
// R17: Bypassed source field: 0 main, 1 internal, 2 internal/4, 3 the 30 kHz osc.
// R18: Only the main oscillator feeds the PLL; PLL used when not bypassed, field 0.
// R19: With bypass set, extended field value 7 selects the real-time oscillator.
// R20: Cause bits are sticky; power-on or pin reset clears all other bits.
// R21: When the extended clock config is in use its fields take precedence.
// R22: Peripheral reset is held while its control bit stays set.
// R23: Clock source switching is glitch free.

// Peripheral reset registers and their width
`define RCS_PRST_REGS      3
`define RCS_PRST_BITS      32
// Clock domains per peripheral unit
`define RCS_DOMAINS        2
// Reset cause bit positions
`define RCS_CAUSE_EXT      0
`define RCS_CAUSE_POR      1
`define RCS_CAUSE_BOR      2
`define RCS_CAUSE_WDT      3
`define RCS_CAUSE_SW       4
`define RCS_CAUSE_W        5
// Internal reset pulse length for software and watchdog requests
`define RCS_RST_PULSE_NS   500
`define RCS_RST_PULSE_CYC  ((`RCS_RST_PULSE_NS + 49) / 50)
// Regulator adjust codes: 0x00 is 2.50 V, steps of 50 mV, 2.25 V .. 2.75 V
`define RCS_VOLTAGE_ADJUST_W         6
`define RCS_VOLTAGE_ADJUST_RESET     6'h00
`define RCS_VOLTAGE_ADJUST_MIN       6'h1B
`define RCS_VOLTAGE_ADJUST_MAX       6'h05
// Source select codes
`define RCS_SRC_MAIN       3'h0
`define RCS_SRC_INT        3'h1
`define RCS_SRC_INT4       3'h2
`define RCS_SRC_LF         3'h3
`define RCS_SRC_RTC        3'h7
// Clock select index (binary mux position)
`define RCS_NCLK           6
`define RCS_CLK_PLL        3'h5
`define RCS_WDT_RESET      32'hFFFF_FFFF
`endif

//--- rtl/rcs_pkg.sv
package rcs_pkg;
	typedef enum logic [1:0] {
		RCS_IDLE,
		RCS_HOLD,
		RCS_RELEASE
	} rcs_rst_state_t;

	typedef enum logic [1:0] {
		RCS_WD_COUNT,
		RCS_WD_ARMED,
		RCS_WD_FIRED
	} rcs_wd_state_t;
endpackage : rcs_pkg

//--- rtl/rcs_watchdog.sv
`include "rcs_defines.svh"
module rcs_watchdog (
	input  wire logic        clk_i,       // System clock
	input  wire logic        srst_i,      // Synchronous reset
	input  wire logic        enable_i,    // Counting enabled
	input  wire logic        rst_en_i,    // Reset output enabled
	input  wire logic [31:0] load_i,      // Reload value
	input  wire logic        reload_i,    // Software service, reloads counter
	input  wire logic        int_clr_i,   // Clear first time-out interrupt
	output logic             irq_o,       // First time-out interrupt
	output logic             reset_req_o  // Second time-out reset request pulse
);
	logic [31:0]               count;
	logic [31:0]               next_count;
	logic                      next_irq;
	logic                      next_reset_req;
	rcs_pkg::rcs_wd_state_t    state;
	rcs_pkg::rcs_wd_state_t    next_state;
	logic                      zero;

	assign zero = (count == 32'h0000_0000);

	always_comb begin
		next_count     = count;
		next_irq       = irq_o;
		next_reset_req = 1'b0;
		next_state     = state;
		if (reload_i) begin
			next_count = load_i;
		end else if (enable_i) begin
			if (zero) begin
				next_count = load_i;                              // [R11]
				if (irq_o && rst_en_i) begin
					next_reset_req = 1'b1;                    // [R12]
				end
				next_irq = 1'b1;                                  // [R10]
			end else begin
				next_count = count - 32'h0000_0001;
			end
		end
		// Set wins over clear so a time-out is never lost
		if (int_clr_i && !(enable_i && zero && !reload_i)) begin
			next_irq = 1'b0;
		end
		next_state = next_irq ? rcs_pkg::RCS_WD_ARMED : rcs_pkg::RCS_WD_COUNT;
		if (next_reset_req) begin
			next_state = rcs_pkg::RCS_WD_FIRED;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			count       <= `RCS_WDT_RESET;
			irq_o       <= 1'b0;
			reset_req_o <= 1'b0;
			state       <= rcs_pkg::RCS_WD_COUNT;
		end else begin
			count       <= next_count;
			irq_o       <= next_irq;
			reset_req_o <= next_reset_req;
			state       <= next_state;
		end
	end
endmodule : rcs_watchdog

//--- rtl/rcs_clk_switch.sv
`include "rcs_defines.svh"
// Glitch-free clock select. Sources are modelled as clock-enable style levels sampled
// on clk_i; a switch waits for the old source to be low before the new one is taken.
module rcs_clk_switch (
	input  wire logic                   clk_i,   // System clock
	input  wire logic                   srst_i,  // Synchronous reset
	input  wire logic [`RCS_NCLK-1:0]   src_i,   // Source levels
	input  wire logic [2:0]             sel_i,   // Requested source index
	output logic                        clk_o,   // Selected clock level
	output logic [2:0]                  cur_o    // Source index in use
);
	logic [2:0] next_cur;
	logic       next_clk;

	always_comb begin
		next_cur = cur_o;
		next_clk = src_i[cur_o];
		// Only hand over while both old and new are low: no shortened pulse
		if (sel_i != cur_o && !src_i[cur_o] && !src_i[sel_i]) begin
			next_cur = sel_i;                                          // [R23]
			next_clk = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			cur_o <= `RCS_SRC_INT;                                     // [R14]
			clk_o <= 1'b0;
		end else begin
			cur_o <= next_cur;
			clk_o <= next_clk;
		end
	end
endmodule : rcs_clk_switch

//--- rtl/rcs_top.sv
`include "rcs_defines.svh"
module rcs_top (
	input  wire logic                    clk_i,                 // 20 MHz system clock
	input  wire logic                    srst_i,                // Synchronous reset
	input  wire logic                    por_i,                 // Power-on reset level
	input  wire logic                    ext_rst_n_i,           // External reset pin, low
	input  wire logic                    brownout_i,            // Brown-out detector level
	input  wire logic                    brownout_reset_enable_i, // Brown-out may reset
	input  wire logic                    system_reset_request_i, // Software system reset
	input  wire logic                    cause_clr_i,           // Clear all cause bits
	input  wire logic [`RCS_PRST_BITS-1:0] prst0_i,             // Peripheral reset reg 0
	input  wire logic [`RCS_PRST_BITS-1:0] prst1_i,             // Peripheral reset reg 1
	input  wire logic [`RCS_PRST_BITS-1:0] prst2_i,             // Peripheral reset reg 2
	input  wire logic                    wdt_enable_i,          // Watchdog counting
	input  wire logic                    wdt_rst_en_i,          // Watchdog reset enable
	input  wire logic [31:0]             watchdog_reload_value_i, // Watchdog load
	input  wire logic                    wdt_service_i,         // Watchdog reload strobe
	input  wire logic                    wdt_int_clr_i,         // Watchdog int clear
	input  wire logic [`RCS_VOLTAGE_ADJUST_W-1:0]  voltage_adjust_i,      // Regulator adjust
	input  wire logic                    bypass_i,              // Basic bypass bit
	input  wire logic [1:0]              osc_source_select_i,   // Basic source field
	input  wire logic                    use_ext_cfg_i,         // Extended config in use
	input  wire logic                    bypass_ext_i,          // Extended bypass bit
	input  wire logic [2:0]              osc_source_select_ext_i, // Extended field
	input  wire logic                    main_osc_i,            // Main oscillator level
	input  wire logic                    internal_osc_i,        // 12 MHz osc level
	input  wire logic                    lf_osc_i,              // 30 kHz osc level
	input  wire logic                    rtc_osc_i,             // Real-time osc level
	input  wire logic                    pll_i,                 // PLL output level
	output logic                         core_rst_o,            // Internal core reset
	output logic                         periph_rst_o,          // Internal periph reset
	output logic                         brownout_irq_o,        // Brown-out interrupt
	output logic                         wdt_irq_o,             // Watchdog interrupt
	output logic [`RCS_CAUSE_W-1:0]      reset_cause_o,         // Reset cause bits
	output logic [`RCS_PRST_REGS*`RCS_PRST_BITS*`RCS_DOMAINS-1:0] prst_domain_o, // Unit resets
	output logic [`RCS_VOLTAGE_ADJUST_W-1:0]       regulator_control_o,   // Applied adjust code
	output logic                         system_clock_o,        // Selected clock level
	output logic [2:0]                   clk_src_o,             // Source index in use
	output logic                         pll_ref_main_o         // PLL reference is main osc
);
	localparam int NP = `RCS_PRST_REGS * `RCS_PRST_BITS;

	rcs_pkg::rcs_rst_state_t        state;
	rcs_pkg::rcs_rst_state_t        next_state;
	logic [7:0]                     cnt;
	logic [7:0]                     next_cnt;
	logic                           next_core_rst;
	logic                           next_brownout_irq;
	logic [`RCS_CAUSE_W-1:0]        next_cause;
	logic [NP*`RCS_DOMAINS-1:0]     next_prst;
	logic [`RCS_VOLTAGE_ADJUST_W-1:0]         next_voltage_adjust;
	logic [NP-1:0]                  prst_all;
	logic                           wdt_req;
	logic                           wdt_irq;
	logic                           bor_rst;
	logic                           hard_rst;
	logic                           pin_rst;
	logic                           eff_bypass;
	logic [2:0]                     eff_src;
	logic [2:0]                     sel_idx;
	logic                           int_div4;
	logic [1:0]                     div_cnt;
	logic [`RCS_NCLK-1:0]           src_vec;

	// Adjust codes wrap around 2.50 V; out-of-range codes would leave 2.25..2.75 V
	function automatic logic voltage_adjust_ok(input logic [`RCS_VOLTAGE_ADJUST_W-1:0] v);
		voltage_adjust_ok = (v <= `RCS_VOLTAGE_ADJUST_MAX) || (v >= `RCS_VOLTAGE_ADJUST_MIN);
	endfunction : voltage_adjust_ok

	// Maps the effective bypass and source fields to a mux index
	function automatic logic [2:0] clk_index(input logic byp, input logic [2:0] src);
		clk_index = `RCS_SRC_INT;
		if (!byp) begin
			clk_index = (src == `RCS_SRC_MAIN) ? `RCS_CLK_PLL : `RCS_SRC_INT; // [R18]
		end else begin
			unique case (src)
				`RCS_SRC_MAIN: clk_index = `RCS_SRC_MAIN;          // [R17]
				`RCS_SRC_INT:  clk_index = `RCS_SRC_INT;           // [R17]
				`RCS_SRC_INT4: clk_index = `RCS_SRC_INT4;          // [R17]
				`RCS_SRC_LF:   clk_index = `RCS_SRC_LF;            // [R17]
				`RCS_SRC_RTC:  clk_index = 3'h4;                   // [R19]
				default:       clk_index = `RCS_SRC_INT;
			endcase
		end
	endfunction : clk_index

	assign pin_rst  = por_i || !ext_rst_n_i;
	assign bor_rst  = brownout_i && brownout_reset_enable_i;           // [R1] [R2]
	// Brown-out joins the pin path and holds for as long as brownout_i is high
	assign hard_rst = pin_rst || bor_rst;                              // [R3]
	assign prst_all = {prst2_i, prst1_i, prst0_i};

	// Extended fields win when in use
	assign eff_bypass = use_ext_cfg_i ? bypass_ext_i : bypass_i;       // [R21]
	assign eff_src    = use_ext_cfg_i ? osc_source_select_ext_i
	                                  : {1'b0, osc_source_select_i};   // [R21]
	assign sel_idx    = clk_index(eff_bypass, eff_src);
	assign src_vec    = {pll_i, rtc_osc_i, lf_osc_i, int_div4, internal_osc_i, main_osc_i}; // [R16]

	rcs_watchdog u_wdt (
		.clk_i       (clk_i),
		.srst_i      (srst_i || por_i),
		.enable_i    (wdt_enable_i),
		.rst_en_i    (wdt_rst_en_i),
		.load_i      (watchdog_reload_value_i),
		.reload_i    (wdt_service_i),
		.int_clr_i   (wdt_int_clr_i),
		.irq_o       (wdt_irq),
		.reset_req_o (wdt_req)
	);

	rcs_clk_switch u_clk (
		.clk_i  (clk_i),
		.srst_i (srst_i || por_i),
		.src_i  (src_vec),
		.sel_i  (sel_idx),
		.clk_o  (system_clock_o),
		.cur_o  (clk_src_o)
	);

	// Internal oscillator divide-by-four, counted on its rising levels
	logic int_prev;
	logic [1:0] next_div_cnt;
	always_comb begin
		next_div_cnt = div_cnt;
		if (internal_osc_i && !int_prev) begin
			next_div_cnt = div_cnt + 2'h1;
		end
	end
	assign int_div4 = div_cnt[1];

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			div_cnt  <= 2'h0;
			int_prev <= 1'b0;
		end else begin
			div_cnt  <= next_div_cnt;
			int_prev <= internal_osc_i;
		end
	end

	// Reset sequencer, cause register, peripheral resets and regulator
	always_comb begin
		next_state        = state;
		next_cnt          = cnt;
		next_core_rst     = core_rst_o;
		next_cause        = reset_cause_o;
		next_brownout_irq = brownout_irq_o;
		next_voltage_adjust         = regulator_control_o;
		next_prst         = '0;

		if (cause_clr_i) begin
			next_cause = '0;
		end

		unique case (state)
			rcs_pkg::RCS_IDLE: begin
				next_core_rst = 1'b0;
				if (system_reset_request_i || wdt_req) begin
					next_state    = rcs_pkg::RCS_HOLD;             // [R8] [R9]
					// The release cycle adds one, so load one short of the pulse
					next_cnt      = 8'(`RCS_RST_PULSE_CYC - 1);
					next_core_rst = 1'b1;
				end
			end
			rcs_pkg::RCS_HOLD: begin
				next_core_rst = 1'b1;
				if (cnt <= 8'h01) begin
					next_state = rcs_pkg::RCS_RELEASE;
				end else begin
					next_cnt = cnt - 8'h01;
				end
			end
			rcs_pkg::RCS_RELEASE: begin
				next_core_rst = 1'b0;                              // [R9]
				next_state    = rcs_pkg::RCS_IDLE;
			end
		endcase

		if (system_reset_request_i) begin
			next_cause[`RCS_CAUSE_SW] = 1'b1;
		end
		if (wdt_req) begin
			next_cause[`RCS_CAUSE_WDT] = 1'b1;
		end

		if (hard_rst) begin
			next_state    = rcs_pkg::RCS_HOLD;
			next_cnt      = 8'(`RCS_RST_PULSE_CYC - 1);
			next_core_rst = 1'b1;                                  // [R3]
			if (bor_rst) begin
				next_cause[`RCS_CAUSE_BOR] = 1'b1;                 // [R4] [R20]
			end
			if (por_i) begin
				next_cause = '0;
				next_cause[`RCS_CAUSE_POR] = 1'b1;                 // [R20]
			end
			if (!ext_rst_n_i) begin
				if (!por_i) begin
					next_cause = '0;
				end
				next_cause[`RCS_CAUSE_EXT] = 1'b1;                 // [R20]
			end
		end

		// Brown-out interrupt when resetting is not enabled; set wins over clear
		if (brownout_i && !brownout_reset_enable_i) begin
			next_brownout_irq = 1'b1;                              // [R2]
		end else if (cause_clr_i || !brownout_i) begin
			next_brownout_irq = 1'b0;
		end

		// Each peripheral bit drives the resets of all its clock domains
		for (int i = 0; i < NP; i++) begin
			for (int d = 0; d < `RCS_DOMAINS; d++) begin
				next_prst[i*`RCS_DOMAINS+d] = prst_all[i] || next_core_rst; // [R5] [R6] [R7] [R22]
			end
		end

		// Only in-range adjust codes are applied to the regulator
		if (voltage_adjust_ok(voltage_adjust_i)) begin
			next_voltage_adjust = voltage_adjust_i;                          // [R13]
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state               <= rcs_pkg::RCS_IDLE;
			cnt                 <= 8'h00;
			core_rst_o          <= 1'b0;
			periph_rst_o        <= 1'b0;
			reset_cause_o       <= '0;
			brownout_irq_o      <= 1'b0;
			wdt_irq_o           <= 1'b0;
			prst_domain_o       <= '0;
			regulator_control_o <= `RCS_VOLTAGE_ADJUST_RESET;
			pll_ref_main_o      <= 1'b1;
		end else begin
			state               <= next_state;
			cnt                 <= next_cnt;
			core_rst_o          <= next_core_rst;
			periph_rst_o        <= next_core_rst;
			reset_cause_o       <= next_cause;
			brownout_irq_o      <= next_brownout_irq;
			wdt_irq_o           <= wdt_irq;
			prst_domain_o       <= next_prst;
			regulator_control_o <= next_voltage_adjust;
			pll_ref_main_o      <= 1'b1;                           // [R18]
		end
	end
endmodule : rcs_top

//--- tb/rcs_top_assertions.sv
`include "rcs_defines.svh"
module rcs_top_checker (
	input wire logic        clk_i,                   // Clock
	input wire logic        srst_i,                  // Reset
	input wire logic        por_i,                   // Power-on
	input wire logic        ext_rst_n_i,             // Pin reset
	input wire logic        brownout_i,              // Low supply
	input wire logic        brownout_reset_enable_i, // Brown-out may reset
	input wire logic        system_reset_request_i,  // Software reset
	input wire logic        wdt_rst_en_i,            // Watchdog reset enable
	input wire logic [31:0] prst0_i,                 // Unit resets 0
	input wire logic [31:0] prst1_i,                 // Unit resets 1
	input wire logic [31:0] prst2_i,                 // Unit resets 2
	input wire logic [5:0]  voltage_adjust_i,        // Adjust code
	input wire logic        core_rst_o,              // Core reset
	input wire logic        periph_rst_o,            // Periph reset
	input wire logic        brownout_irq_o,          // Brown-out irq
	input wire logic [4:0]  reset_cause_o,           // Cause bits
	input wire logic [191:0] prst_domain_o,          // Domain resets
	input wire logic [5:0]  regulator_control_o,     // Applied code
	input wire logic        system_clock_o,          // Clock level
	input wire logic [2:0]  clk_src_o                // Source in use
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam int NP = `RCS_PRST_REGS * `RCS_PRST_BITS;
	logic [NP-1:0]   req;
	logic [2*NP-1:0] fan;
	logic            calm;
	logic            vok;
	assign req = {prst2_i, prst1_i, prst0_i};
	assign calm = !por_i && ext_rst_n_i && !system_reset_request_i;
	assign vok = voltage_adjust_i <= `RCS_VOLTAGE_ADJUST_MAX || voltage_adjust_i >= `RCS_VOLTAGE_ADJUST_MIN;
	always_comb begin
		for (int i = 0; i < NP; i++)
			fan[2*i +: 2] = {2{req[i]}};
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);
	AST_NO_RST:
	assert property (calm && !(brownout_i && brownout_reset_enable_i) && !wdt_rst_en_i
		&& !core_rst_o |=> !core_rst_o) else $error("Unrequested core reset");
	AST_BOR_IRQ:
	assert property (brownout_i && !brownout_reset_enable_i && calm && !core_rst_o
		|=> brownout_irq_o) else $error("Brown-out gave no interrupt");
	AST_BOR_RST:
	assert property (brownout_i && brownout_reset_enable_i && !por_i && ext_rst_n_i
		|=> core_rst_o && reset_cause_o[`RCS_CAUSE_BOR]) else $error("Brown-out reset missing");
	AST_SW_PULSE:
	assert property ($rose(system_reset_request_i) && !por_i && ext_rst_n_i && !brownout_i
		&& !core_rst_o |=> core_rst_o && periph_rst_o && reset_cause_o[`RCS_CAUSE_SW]
		##1 core_rst_o [*8] ##1 core_rst_o ##1 !core_rst_o) else $error("Bad reset pulse");
	AST_PRST_FAN:
	assert property (!periph_rst_o && !$past(periph_rst_o) |-> prst_domain_o == $past(fan))
		else $error("Unit reset fan-out wrong");
	AST_POR_CAUSE:
	assert property (por_i |=> reset_cause_o == 5'h02) else $error("Power-on cause wrong");
	AST_PIN_CAUSE:
	assert property (!ext_rst_n_i && !por_i |=> reset_cause_o == 5'h01)
		else $error("Pin reset cause wrong");
	AST_VOLTAGE_ADJUST:
	assert property (1'h1 |=> regulator_control_o ==
		($past(vok) ? $past(voltage_adjust_i) : $past(regulator_control_o)))
		else $error("Regulator code wrong");
	AST_CLK_POR:
	assert property ($fell(srst_i) |-> clk_src_o == 3'h1) else $error("Start source wrong");
	AST_CLK_GLITCH:
	assert property ($changed(clk_src_o) |-> !system_clock_o) else $error("Switch while high");
endmodule : rcs_top_checker

//--- tb/rcs_osc_model.sv
module rcs_osc_model #(
	parameter int STAB_CYC = 40 // Main oscillator start-up in clk_i cycles
) (
	input  wire logic  clk_i,        // Bench clock
	input  wire logic  main_en_i,    // Main oscillator enable
	output logic       main_ready_o, // Main oscillator stable
	output logic [4:0] src_o         // pll, rtc, lf, internal, main levels
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [4:0] cnt = 5'h00;
	int         stab = 0;
	always @(posedge clk_i) begin
		cnt <= cnt + 5'h01;
		if (!main_en_i)
			stab <= 0;
		else if (stab < STAB_CYC)
			stab <= stab + 1;
	end
	assign main_ready_o = stab >= STAB_CYC;
	// A stopped main oscillator rests low, and so does the PLL it feeds
	assign src_o = {cnt[2] & main_ready_o, cnt[4], cnt[3], cnt[0], cnt[1] & main_ready_o};
endmodule : rcs_osc_model

//--- tb/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int          PI [3] = '{0, 33, 95};
	localparam logic [11:0] VT [6] = '{12'h145, 12'h185, 12'h6DB, 12'h69B, 12'hFFF, 12'h000};
	localparam logic [10:0] CT [7] = '{11'h020, 11'h005, 11'h032, 11'h03B, 11'h7EC, 11'h6C3,
		11'h029};
	logic         clk_i = 1'h0, srst_i = 1'h1, por_i = 1'h0, ext_rst_n_i = 1'h1;
	logic         brownout_i = 1'h0, brownout_reset_enable_i = 1'h0, cause_clr_i = 1'h0;
	logic         system_reset_request_i = 1'h0, wdt_enable_i = 1'h0, wdt_rst_en_i = 1'h0;
	logic         wdt_service_i = 1'h0, wdt_int_clr_i = 1'h0, main_en = 1'h0;
	logic         bypass_i = 1'h1, use_ext_cfg_i = 1'h0, bypass_ext_i = 1'h0;
	logic [1:0]   osc_source_select_i = 2'h1;
	logic [2:0]   osc_source_select_ext_i = 3'h0;
	logic [5:0]   voltage_adjust_i = 6'h00;
	logic [31:0]  watchdog_reload_value_i = 32'h0000_0005;
	logic [95:0]  pr = '0;
	wire  [31:0]  prst0_i, prst1_i, prst2_i;
	wire  [4:0]   src;
	wire          main_osc_i, internal_osc_i, lf_osc_i, rtc_osc_i, pll_i, main_rdy;
	logic         core_rst_o, periph_rst_o, brownout_irq_o, wdt_irq_o, system_clock_o;
	logic         pll_ref_main_o;
	logic [4:0]   reset_cause_o;
	logic [191:0] prst_domain_o;
	logic [5:0]   regulator_control_o;
	logic [2:0]   clk_src_o;
	int           bad_count = 0, total_checks = 0, n;
	assign {prst2_i, prst1_i, prst0_i} = pr;
	assign {pll_i, rtc_osc_i, lf_osc_i, internal_osc_i, main_osc_i} = src;
	always #25 clk_i = ~clk_i;
	rcs_osc_model osc (.clk_i, .main_en_i(main_en), .main_ready_o(main_rdy), .src_o(src));
	rcs_top dut (.clk_i, .srst_i, .por_i, .ext_rst_n_i, .brownout_i, .brownout_reset_enable_i,
		.system_reset_request_i, .cause_clr_i, .prst0_i, .prst1_i, .prst2_i, .wdt_enable_i,
		.wdt_rst_en_i, .watchdog_reload_value_i, .wdt_service_i, .wdt_int_clr_i,
		.voltage_adjust_i, .bypass_i, .osc_source_select_i, .use_ext_cfg_i, .bypass_ext_i,
		.osc_source_select_ext_i, .main_osc_i, .internal_osc_i, .lf_osc_i, .rtc_osc_i, .pll_i,
		.core_rst_o, .periph_rst_o, .brownout_irq_o, .wdt_irq_o, .reset_cause_o,
		.prst_domain_o, .regulator_control_o, .system_clock_o, .clk_src_o, .pll_ref_main_o);
	task automatic tk(input int c);
		repeat (c) @(posedge clk_i);
	endtask : tk
	// Samples a little after the edge so the design's updates have landed
	task automatic tks(input int c);
		repeat (c) @(posedge clk_i);
		#1;
	endtask : tks
	task automatic wcr(input logic v);
		#1;
		for (n = 0; n < 100 && core_rst_o !== v; n++)
			tks(1);
	endtask : wcr
	task automatic ck(input logic [191:0] seen, input logic [191:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : ck
	task automatic done(input string name);
		$display("Test %s finished", name);
	endtask : done
	task automatic conclude();
		$display("Checks %0d, mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : conclude
	initial begin
		#(50 * 20000);
		bad_count++;
		conclude();
	end
	initial begin
		tk(16);
		srst_i <= 1'h0;
		tks(1);
		ck(clk_src_o, 3'h1);
		ck(pll_ref_main_o, 1'h1);
		done("reset");
		tk(1);
		brownout_i <= 1'h1;
		tks(5);
		ck(brownout_irq_o, 1'h1);
		ck(core_rst_o, 1'h0);
		tk(1);
		brownout_i <= 1'h0;
		cause_clr_i <= 1'h1;
		tk(1);
		cause_clr_i <= 1'h0;
		tks(1);
		ck(brownout_irq_o, 1'h0);
		brownout_reset_enable_i <= 1'h1;
		brownout_i <= 1'h1;
		tks(20);
		ck(core_rst_o, 1'h1);
		ck(reset_cause_o[2], 1'h1);
		tk(1);
		brownout_i <= 1'h0;
		wcr(1'h0);
		ck(n >= 10 && n <= 13, 1'h1);
		brownout_reset_enable_i <= 1'h0;
		done("brownout");
		tk(1);
		system_reset_request_i <= 1'h1;
		tk(1);
		system_reset_request_i <= 1'h0;
		#1;
		ck(core_rst_o & periph_rst_o, 1'h1);
		ck(reset_cause_o[4] & reset_cause_o[2], 1'h1);
		ck(prst_domain_o, {192{1'h1}});
		wcr(1'h0);
		ck(n, 10);
		done("software reset");
		foreach (PI[k]) begin
			tk(1);
			pr[PI[k]] <= 1'h1;
			tks(6);
			ck(prst_domain_o, 192'h3 << (2 * PI[k]));
			pr <= '0;
			tks(2);
			ck(prst_domain_o, 192'h0);
		end
		done("peripheral reset");
		tk(1);
		wdt_rst_en_i <= 1'h1;
		wdt_service_i <= 1'h1;
		tk(1);
		wdt_service_i <= 1'h0;
		wdt_enable_i <= 1'h1;
		repeat (3) begin
			for (n = 0; n < 30 && wdt_irq_o !== 1'h1; n++)
				tks(1);
			ck(n < 30, 1'h1);
			wdt_int_clr_i <= 1'h1;
			tks(1);
			wdt_int_clr_i <= 1'h0;
			tks(2);
		end
		ck(reset_cause_o[3], 1'h0);
		wcr(1'h1);
		ck(n < 20, 1'h1);
		ck(reset_cause_o[3], 1'h1);
		wdt_enable_i <= 1'h0;
		wdt_rst_en_i <= 1'h0;
		wcr(1'h0);
		done("watchdog");
		tk(1);
		ext_rst_n_i <= 1'h0;
		tk(3);
		ext_rst_n_i <= 1'h1;
		tks(1);
		ck(reset_cause_o, 5'h01);
		wcr(1'h0);
		tk(1);
		por_i <= 1'h1;
		tk(3);
		por_i <= 1'h0;
		tks(1);
		ck(reset_cause_o, 5'h02);
		wcr(1'h0);
		done("hard resets");
		foreach (VT[k]) begin
			tk(1);
			voltage_adjust_i <= VT[k][11:6];
			tks(2);
			ck(regulator_control_o, VT[k][5:0]);
		end
		done("regulator");
		tk(1);
		main_en <= 1'h1;
		for (n = 0; n < 100 && main_rdy !== 1'h1; n++)
			tks(1);
		ck(main_rdy, 1'h1);
		foreach (CT[k]) begin
			tk(1);
			{use_ext_cfg_i, bypass_ext_i, osc_source_select_ext_i, bypass_i,
				osc_source_select_i} <= CT[k][10:3];
			for (n = 0; n < 200 && clk_src_o !== CT[k][2:0]; n++)
				tks(1);
			ck(clk_src_o, CT[k][2:0]);
		end
		done("clock select");
		conclude();
	end
endmodule : tb_top
bind rcs_top rcs_top_checker chk (.clk_i, .srst_i, .por_i, .ext_rst_n_i, .brownout_i,
	.brownout_reset_enable_i, .system_reset_request_i, .wdt_rst_en_i, .prst0_i, .prst1_i,
	.prst2_i, .voltage_adjust_i, .core_rst_o, .periph_rst_o, .brownout_irq_o, .reset_cause_o,
	.prst_domain_o, .regulator_control_o, .system_clock_o, .clk_src_o);
